// File: logic/sbdf_top.sv
// Chosen here: the AXI4-Lite slave port.
`include "sbdf_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sbdf_top #(
    parameter int HALF_DIV = `SBDF_HALF_DIV
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe_n,
    input wire logic ss_n_in,
    output logic irq
);
    localparam logic [`SBDF_DIV_W-1:0] HALF_M1 = `SBDF_DIV_W'(HALF_DIV - 1);

    if (HALF_DIV < `SBDF_MIN_DIV || HALF_DIV > (1 << `SBDF_DIV_W)) begin : g_bad
        $error("sbdf_top: half period out of range");
    end

    sbdf_pkg::sbdf_st_t st;
    sbdf_pkg::sbdf_st_t n;
    sbdf_pkg::sbdf_pins_t pin;
    logic rise;
    logic fall;
    logic start;
    logic done;
    logic lost;
    logic tx_pend;
    logic direct;
    logic rd_data;
    logic [7:0] rb;
    logic [7:0] fl;

    // pins come from another domain, so two flops first
    sbdf_sync #(
        .W(3)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d({sck_in, sdi, ss_n_in}),
        .q(pin)
    );

    always_comb begin
        n = st;
        rise = 1'b0;
        fall = 1'b0;
        start = 1'b0;
        done = 1'b0;
        lost = 1'b0;
        tx_pend = 1'b0;
        rd_data = 1'b0;
        rb = `SBDF_RST_BYTE;
        fl = `SBDF_RST_BYTE;
        direct = st.wfr && st.en && pin.ss_n && !st.sh_full &&
                 st.fsm == sbdf_pkg::SBDF_IDLE && st.cnt == `SBDF_ZERO_BIT;
        fl[`SBDF_B_DRE] = !st.tx_v;
        fl[`SBDF_B_RXC] = st.rcf;
        fl[`SBDF_B_TXC] = st.tcf;
        fl[`SBDF_B_HDF] = st.hdf;
        fl[`SBDF_B_OVF] = st.ovf;

        if (st.awready && s_axi_awvalid) begin
            n.aw_v = 1'b1;
            n.aw_a = s_axi_awaddr[7:2];
        end
        if (st.wready && s_axi_wvalid) begin
            n.w_v = 1'b1;
            n.w_d = s_axi_wdata[7:0];
            n.w_s = s_axi_wstrb[0];
        end
        if (st.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (st.aw_v && st.w_v && !st.bvalid) begin
            n.aw_v = 1'b0;
            n.w_v = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = `SBDF_RESP_OK;
            case (st.aw_a)
                `SBDF_IDX_CTRLA: begin
                    if (st.w_s) begin
                        n.en = st.w_d[`SBDF_B_EN];
                        n.host = st.w_d[`SBDF_B_HOST];
                    end
                end
                `SBDF_IDX_CTRLB: begin
                    if (st.w_s) begin
                        n.buffer_mode_enable = st.w_d[`SBDF_B_BUFFER_MODE_ENABLE];
                        n.wfr = st.w_d[`SBDF_B_WFR];
                        n.select_line_ignore = st.w_d[`SBDF_B_SSD];
                    end
                end
                `SBDF_IDX_IEN: begin
                    if (st.w_s) begin
                        n.ie = st.w_d[`SBDF_IE_HI:`SBDF_IE_LO];
                    end
                end
                `SBDF_IDX_FLAGS: begin
                    if (st.w_s && st.w_d[`SBDF_B_RXC]) begin
                        n.rcf = 1'b0;
                    end
                    if (st.w_s && st.w_d[`SBDF_B_TXC]) begin
                        n.tcf = 1'b0;
                    end
                    if (st.w_s && st.w_d[`SBDF_B_HDF]) begin
                        n.hdf = 1'b0;
                    end
                    if (st.w_s && st.w_d[`SBDF_B_OVF]) begin
                        n.ovf = 1'b0;
                    end
                end
                `SBDF_IDX_DATA: begin
                    if (st.w_s) begin
                        if (!st.buffer_mode_enable || direct) begin
                            n.sh = st.w_d;
                            n.sh_full = 1'b1;
                        end else begin
                            n.txb = st.w_d;
                            n.tx_v = 1'b1;
                        end
                    end
                end
                default: begin
                    n.bresp = `SBDF_RESP_ERR;
                end
            endcase
        end

        if (st.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (st.arready && s_axi_arvalid) begin
            n.rvalid = 1'b1;
            n.rresp = `SBDF_RESP_OK;
            n.rdata = `SBDF_RST_BYTE;
            case (s_axi_araddr[7:2])
                `SBDF_IDX_CTRLA: begin
                    n.rdata[`SBDF_B_EN] = st.en;
                    n.rdata[`SBDF_B_HOST] = st.host;
                end
                `SBDF_IDX_CTRLB: begin
                    n.rdata[`SBDF_B_BUFFER_MODE_ENABLE] = st.buffer_mode_enable;
                    n.rdata[`SBDF_B_WFR] = st.wfr;
                    n.rdata[`SBDF_B_SSD] = st.select_line_ignore;
                end
                `SBDF_IDX_IEN: begin
                    n.rdata[`SBDF_IE_HI:`SBDF_IE_LO] = st.ie;
                end
                `SBDF_IDX_FLAGS: begin
                    n.rdata = fl;
                end
                `SBDF_IDX_DATA: begin
                    rd_data = 1'b1;
                    n.rdata = st.rx0;
                    n.ovf = 1'b0;
                    if (st.buffer_mode_enable) begin
                        n.rx0 = st.rx1;
                        n.rx0_v = st.rx1_v;
                        n.rx1_v = 1'b0;
                    end else begin
                        n.rx0_v = 1'b0;
                    end
                end
                default: begin
                    n.rresp = `SBDF_RESP_ERR;
                end
            endcase
        end
        n.rcf = n.rcf && n.rx0_v;

        case (st.fsm)
            sbdf_pkg::SBDF_IDLE: begin
                if (st.en && st.host && (st.sh_full || (st.buffer_mode_enable && st.tx_v))) begin
                    n.fsm = sbdf_pkg::SBDF_SHIFT;
                    n.div = '0;
                end
            end
            sbdf_pkg::SBDF_SHIFT, sbdf_pkg::SBDF_TAIL: begin
                if (st.div == HALF_M1) begin
                    n.div = '0;
                    n.sck_out = !st.sck_out;
                    rise = !st.sck_out;
                    fall = st.sck_out;
                end else begin
                    n.div = st.div + 1'b1;
                end
                if (st.fsm == sbdf_pkg::SBDF_TAIL && fall) begin
                    n.fsm = sbdf_pkg::SBDF_IDLE;
                end
            end
            default: begin
                n.fsm = sbdf_pkg::SBDF_IDLE;
            end
        endcase
        // client waits for the peer clock
        if (!st.host) begin
            if (pin.ss_n) begin
                n.cnt = `SBDF_ZERO_BIT;
            end else if (st.en) begin
                rise = pin.sck && !st.sck_d;
                fall = !pin.sck && st.sck_d;
            end
        end

        if (rise) begin
            start = st.cnt == `SBDF_ZERO_BIT;
            n.samp = pin.sdi;
            n.cnt = st.cnt + 1'b1;
            if (st.cnt == `SBDF_LAST_BIT) begin
                done = 1'b1;
                rb = {st.sh[6:0], pin.sdi};
            end
        end
        if (fall && st.cnt != `SBDF_ZERO_BIT) begin
            n.sh = {st.sh[6:0], st.samp};
        end
        if (start && st.ovf_pend) begin
            n.ovf = 1'b1;
            n.ovf_pend = 1'b0;
        end
        if (done) begin
            // pending byte as seen before the reload below empties it
            tx_pend = n.tx_v;
            if (st.fsm == sbdf_pkg::SBDF_SHIFT) begin
                n.fsm = sbdf_pkg::SBDF_TAIL;
            end
            if (!st.buffer_mode_enable || !n.rx0_v) begin
                n.rx0 = rb;
                n.rx0_v = 1'b1;
            end else if (!n.rx1_v) begin
                n.rx1 = rb;
                n.rx1_v = 1'b1;
            end else begin
                lost = 1'b1;
                if (tx_pend) begin
                    n.ovf = 1'b1;
                end else begin
                    n.ovf_pend = 1'b1;
                end
            end
            n.rcf = 1'b1;
            if (st.buffer_mode_enable && n.tx_v) begin
                n.sh = n.txb;
                n.tx_v = 1'b0;
                n.sh_full = 1'b1;
            end else begin
                n.sh_full = 1'b0;
                n.tcf = 1'b1;
            end
        end

        if (st.en && st.host && !st.select_line_ignore && !pin.ss_n) begin
            n.host = 1'b0;
            n.hdf = 1'b1;
            n.fsm = sbdf_pkg::SBDF_IDLE;
            n.sck_out = 1'b0;
            n.cnt = `SBDF_ZERO_BIT;
        end

        n.sck_d = pin.sck;
        n.sck_oe_n = !(n.en && n.host);
        n.sdo_oe_n = !(n.en && (n.host || !pin.ss_n));
        n.irq = n.buffer_mode_enable && |({n.rcf, n.tcf, !n.tx_v, n.hdf} & n.ie);
        n.awready = !n.aw_v;
        n.wready = !n.w_v;
        n.arready = !n.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.fsm <= sbdf_pkg::SBDF_IDLE;
            st.sck_oe_n <= 1'b1;
            st.sdo_oe_n <= 1'b1;
        end else begin
            st <= n;
        end
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bresp = st.bresp;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_arready = st.arready;
    assign s_axi_rdata = {`SBDF_RPAD, st.rdata};
    assign s_axi_rresp = st.rresp;
    assign s_axi_rvalid = st.rvalid;
    assign sck_out = st.sck_out;
    assign sck_oe_n = st.sck_oe_n;
    assign sdo = st.sh[7];
    assign sdo_oe_n = st.sdo_oe_n;
    assign irq = st.irq;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    rcf_needs_data_a: assert property (st.rcf |-> st.rx0_v)
        else $error("receive flag set with empty head");
    tcf_on_done_a: assert property (
        done && !(st.buffer_mode_enable && tx_pend) |=> st.tcf && !st.sh_full)
        else $error("transfer flag missed");
    dre_read_a: assert property (
        st.arready && s_axi_arvalid && s_axi_araddr[7:2] == `SBDF_IDX_FLAGS
        |=> st.rdata[`SBDF_B_DRE] == !$past(st.tx_v))
        else $error("empty flag read wrong");
    data_fill_a: assert property (
        st.aw_v && st.w_v && !st.bvalid && st.w_s && st.buffer_mode_enable && !direct &&
        st.aw_a == `SBDF_IDX_DATA && !done |=> st.tx_v ##0 !fl[`SBDF_B_DRE])
        else $error("data write left buffer empty");
    demote_a: assert property (
        st.en && st.host && !st.select_line_ignore && !pin.ss_n
        |=> !st.host && st.hdf && st.sck_oe_n)
        else $error("host not demoted");
    ignore_sel_a: assert property ($rose(st.hdf) |-> !$past(st.select_line_ignore))
        else $error("demotion flag set while ignored");
    ovf_now_a: assert property (lost && tx_pend |=> st.ovf)
        else $error("overflow not flagged");
    ovf_defer_a: assert property (
        lost && !tx_pend |=> st.ovf_pend ##1 (st.ovf_pend || st.ovf))
        else $error("overflow not deferred");
    host_start_a: assert property (
        st.fsm == sbdf_pkg::SBDF_IDLE && st.en && st.host && st.sh_full &&
        pin.ss_n |=> st.fsm == sbdf_pkg::SBDF_SHIFT)
        else $error("host transfer did not start");
    pop_head_a: assert property (
        st.arready && s_axi_arvalid && s_axi_araddr[7:2] == `SBDF_IDX_DATA &&
        st.buffer_mode_enable && st.rx1_v && !done |=> st.rx0 == $past(st.rx1))
        else $error("second stage did not advance");
endmodule // sbdf_top
`default_nettype wire

// File: logic/sbdf_cfg.svh
`ifndef SBDF_CFG_SVH
`define SBDF_CFG_SVH
`define SBDF_IDX_CTRLA 6'h00
`define SBDF_IDX_CTRLB 6'h01
`define SBDF_IDX_IEN 6'h02
`define SBDF_IDX_FLAGS 6'h03
`define SBDF_IDX_DATA 6'h04
`define SBDF_B_EN 0
`define SBDF_B_HOST 5
`define SBDF_B_BUFFER_MODE_ENABLE 7
`define SBDF_B_WFR 6
`define SBDF_B_SSD 2
`define SBDF_B_RXC 7
`define SBDF_B_TXC 6
`define SBDF_B_DRE 5
`define SBDF_B_HDF 4
`define SBDF_B_OVF 0
`define SBDF_IE_HI 7
`define SBDF_IE_LO 4
`define SBDF_RST_BYTE 8'h00
`define SBDF_LAST_BIT 3'h7
`define SBDF_ZERO_BIT 3'h0
`define SBDF_HALF_DIV 4
`define SBDF_MIN_DIV 4
`define SBDF_DIV_W 8
`define SBDF_RESP_OK 2'h0
`define SBDF_RESP_ERR 2'h2
`define SBDF_RPAD 24'h000000
`endif

// File: logic/sbdf_pkg.sv
`include "sbdf_cfg.svh"
package sbdf_pkg;
    typedef enum logic [2:0] {
        SBDF_IDLE = 3'b001,
        SBDF_SHIFT = 3'b010,
        SBDF_TAIL = 3'b100
    } sbdf_fsm_t;

    typedef struct packed {
        logic sck;
        logic sdi;
        logic ss_n;
    } sbdf_pins_t;

    typedef struct packed {
        sbdf_fsm_t fsm;
        logic [2:0] cnt;
        logic [7:0] sh;
        logic samp;
        logic sh_full;
        logic [7:0] txb;
        logic tx_v;
        logic [7:0] rx0;
        logic rx0_v;
        logic [7:0] rx1;
        logic rx1_v;
        logic rcf;
        logic tcf;
        logic hdf;
        logic ovf;
        logic ovf_pend;
        logic en;
        logic host;
        logic buffer_mode_enable;
        logic wfr;
        logic select_line_ignore;
        logic [3:0] ie;
        logic [`SBDF_DIV_W-1:0] div;
        logic sck_out;
        logic sck_oe_n;
        logic sdo_oe_n;
        logic sck_d;
        logic irq;
        logic aw_v;
        logic [5:0] aw_a;
        logic w_v;
        logic [7:0] w_d;
        logic w_s;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
    } sbdf_st_t;
endpackage

// File: logic/sbdf_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sbdf_sync #(
    parameter int W = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } sbdf_sync_t;

    sbdf_sync_t st;
    sbdf_sync_t next_st;

    if (W < 1) begin : g_bad_w
        $error("sbdf_sync: width must be at least one");
    end

    // meta feeds only the second stage
    always_comb begin
        next_st = st;
        next_st.meta = d;
        next_st.q = st.meta;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.q;
endmodule // sbdf_sync
`default_nettype wire

// File: verification/sbdf_peer.sv
`timescale 1ns/1ps
`default_nettype none
module sbdf_peer (
    input wire logic sck_out,
    input wire logic sdo,
    output logic sck_in,
    output logic sdi,
    output logic ss_n_in
);
    logic [7:0] reply = 8'h00;
    logic [7:0] got = 8'h00;
    logic ssq = 1'b1;
    int nbit = 8;
    initial begin
        sck_in = 1'b0;
        sdi = 1'b1;
    end
    assign ss_n_in = ssq;
    // client role: first bit must sit on the line before the first rise
    task automatic arm(input logic [7:0] r);
        reply = r;
        nbit = 0;
        sdi = r[7];
    endtask
    always @(posedge sck_out) begin
        got = {got[6:0], sdo};
        nbit = nbit + 1;
    end
    // once the byte is over the line shows garbage, not the last bit
    always @(negedge sck_out) begin
        if (nbit < 8) begin
            sdi = reply[7 - nbit];
        end else begin
            sdi = ~sdi;
        end
    end
    // host role: link clock runs only inside the frame
    task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
        ssq = 1'b0;
        #48;
        for (int i = 7; i >= 0; i--) begin
            sdi = tx[i];
            #24 sck_in = 1'b1;
            rx[i] = sdo;
            #24 sck_in = 1'b0;
        end
        #24 ssq = 1'b1;
        sdi = ~sdi;
    endtask
endmodule // sbdf_peer
`default_nettype wire

// File: verification/spi_buffered_data_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbdf_cfg.svh"
module spi_buffered_data_flags_tb;
    localparam logic [7:0] CA = {`SBDF_IDX_CTRLA, 2'b00};
    localparam logic [7:0] CB = {`SBDF_IDX_CTRLB, 2'b00};
    localparam logic [7:0] IE = {`SBDF_IDX_IEN, 2'b00};
    localparam logic [7:0] FL = {`SBDF_IDX_FLAGS, 2'b00};
    localparam logic [7:0] DT = {`SBDF_IDX_DATA, 2'b00};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic sck_in, sck_out, sdi, sdo, ss_n_in, irq, sck_oe_n, sdo_oe_n;
    int bad_count = 0;
    int n_compared = 0;
    int rxq[$];
    logic [7:0] tx, rep, d, g, m1, m2;
    logic [1:0] r;
    always #2.5 aclk = ~aclk;
    sbdf_top dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sck_in(sck_in),
        .sck_out(sck_out), .sck_oe_n(sck_oe_n), .sdi(sdi), .sdo(sdo),
        .sdo_oe_n(sdo_oe_n), .ss_n_in(ss_n_in), .irq(irq));
    sbdf_peer peer (.sck_out(sck_out), .sdo(sdo), .sck_in(sck_in),
        .sdi(sdi), .ss_n_in(ss_n_in));
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // address and data channels are released each at its own handshake
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v,
                      output logic [1:0] rr);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge aclk);
        rready <= 1'b0;
        v = rdata[7:0];
        rr = rresp;
        chk(rdata[31:8], 24'h000000);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        logic [1:0] rr;
        rd(a, v, rr);
        chk(v, e);
    endtask
    task automatic wait_flag(input logic [7:0] msk);
        logic [7:0] v;
        logic [1:0] rr;
        v = 8'h00;
        while ((v & msk) !== msk) rd(FL, v, rr);
    endtask
    initial begin
        #400000;
        bad_count++;
        test_done;
    end
    initial begin
        tx = $urandom(54);
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(FL, 8'h20);
        rdc(DT, 8'h00);
        rd(8'hFC, d, r);
        chk(r, `SBDF_RESP_ERR);
        wr(CA, 8'h21);
        wr(CB, 8'hC0);
        chk(sck_oe_n, 1'b0);
        chk(sdo_oe_n, 1'b0);
        // four host transfers with no reads: third and fourth are lost
        for (int k = 0; k < 4; k++) begin
            tx = $urandom;
            rep = $urandom;
            peer.arm(rep);
            wr(DT, tx);
            wait_flag(8'h40);
            chk(peer.got, tx);
            if (rxq.size() < 2) rxq.push_back(rep);
            rdc(FL, 8'hE0 | 8'(k == 3));
            wr(FL, 8'h40);
        end
        wr(FL, 8'h00);
        rdc(FL, 8'hA1);
        rdc(DT, 8'(rxq.pop_front()));
        rdc(FL, 8'hA0);
        rdc(DT, 8'(rxq.pop_front()));
        rdc(FL, 8'h20);
        wr(IE, 8'h20);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b1);
        wr(IE, 8'h00);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b0);
        wr(CB, 8'h00);
        rep = $urandom;
        tx = $urandom;
        peer.arm(rep);
        wr(DT, tx);
        wait_flag(8'h40);
        chk(peer.got, tx);
        rdc(DT, rep);
        wr(FL, 8'hFF);
        wr(CB, 8'h04);
        peer.ssq <= 1'b0;
        repeat (8) @(posedge aclk);
        rdc(FL, 8'h20);
        rdc(CA, 8'h21);
        peer.ssq <= 1'b1;
        wr(CB, 8'h00);
        peer.ssq <= 1'b0;
        repeat (8) @(posedge aclk);
        rdc(FL, 8'h30);
        rdc(CA, 8'h01);
        chk(sck_oe_n, 1'b1);
        chk(sdo_oe_n, 1'b0);
        peer.ssq <= 1'b1;
        wr(FL, 8'h10);
        rdc(FL, 8'h20);
        chk(sdo_oe_n, 1'b1);
        // client, buffered, first frame carries a dummy byte
        wr(CB, 8'h80);
        tx = $urandom;
        wr(DT, tx);
        rdc(FL, 8'h00);
        m1 = $urandom;
        m2 = $urandom;
        peer.frame(m1, g);
        rd(FL, d, r);
        chk(d & 8'hA1, 8'hA0);
        peer.frame(m2, g);
        chk(g, tx);
        // both stages full and a byte pending: third frame flags at once
        tx = $urandom;
        wr(DT, tx);
        rep = $urandom;
        peer.frame(rep, g);
        rd(FL, d, r);
        chk(d & 8'hA1, 8'hA1);
        rdc(DT, m1);
        rdc(DT, m2);
        test_done;
    end
endmodule // spi_buffered_data_flags_tb
`default_nettype wire
